// >>> common/rxprt_pkg.sv
// What this block does
// - Export each finished value when output enabled
// - Export only while serial interface selected
// - Internal trigger: export only after trigger pulse
// - Format ASCII by default, binary optional
// - Percent deviation in reference-percent mode
// - Percent applies to all response paths
// - Percent limited to plus/minus 999.9990
// - Percent mode only: overrange E7, fault +000100.0000E8 codes
// - 9600 baud, 8N1, no handshake
// - Print key prints value and judgment
// - Low print input prints value and judgment with stats and memory off
// - Stats and internal trigger: print adds sample
// - External trigger: print never adds sample
// - Stats print only with memory or stats
// - Stats print trims output by valid count
// - Stats print end clears stats and data
// - Trigger edge falling default, rising selectable
package rxprt_pkg;
  localparam int unsigned RXPRT_CLK_HZ = 20000000;
  localparam int unsigned RXPRT_BAUD = 9600;
  localparam int unsigned RXPRT_BIT_CYC = RXPRT_CLK_HZ / RXPRT_BAUD;
  localparam int unsigned RXPRT_LINE_MAX = 45;
  localparam int unsigned RXPRT_PAIRS_PER_LINE = 3;
  localparam logic [31:0] RXPRT_PCT_LIMIT = 32'h0098_9676;
  localparam logic [3:0] RXPRT_EXP_NORMAL = 4'h0;
  localparam logic [3:0] RXPRT_EXP_OVER = 4'h7;
  localparam logic [3:0] RXPRT_EXP_FAULT = 4'h8;
  localparam logic [31:0] RXPRT_MANT_100 = 32'h000f_4240;
  localparam logic [7:0] RXPRT_CH_CR = 8'h0d;
  localparam logic [7:0] RXPRT_CH_LF = 8'h0a;
  localparam logic [7:0] RXPRT_CH_SP = 8'h20;
  localparam logic [7:0] RXPRT_CH_SLASH = 8'h2f;
  localparam logic [7:0] RXPRT_CH_PLUS = 8'h2b;
  localparam logic [7:0] RXPRT_CH_MINUS = 8'h2d;
  localparam logic [7:0] RXPRT_CH_ZERO = 8'h30;
  localparam logic [7:0] RXPRT_CH_E = 8'h45;
  localparam logic [7:0] RXPRT_CH_H = 8'h48;
  localparam logic [7:0] RXPRT_CH_I = 8'h49;
  localparam logic [7:0] RXPRT_CH_N = 8'h4e;
  localparam logic [7:0] RXPRT_CH_L = 8'h4c;
  localparam logic [7:0] RXPRT_CH_O = 8'h6f;
  localparam logic [7:0] RXPRT_CH_R = 8'h52;
  localparam logic [7:0] RXPRT_CH_S = 8'h53;
  localparam logic [7:0] RXPRT_CH_DOT = 8'h2e;
  localparam logic [7:0] RXPRT_BIN_SYNC = 8'h23;
  localparam logic [3:0] RXPRT_DIGITS = 4'ha;
  localparam logic [3:0] RXPRT_FRAC_POS = 4'h4;
  localparam logic [7:0] RXPRT_ADDR_CTRL = 8'h00;
  localparam logic [7:0] RXPRT_ADDR_STAT = 8'h04;
  localparam logic [7:0] RXPRT_ADDR_VAL = 8'h08;
  localparam logic [7:0] RXPRT_ADDR_REF = 8'h0c;
  localparam logic [7:0] RXPRT_ADDR_MEAS = 8'h10;
  localparam logic [7:0] RXPRT_ADDR_CMD = 8'h14;
  localparam int RXPRT_C_OUT_EN = 0;
  localparam int RXPRT_C_IF_SER = 1;
  localparam int RXPRT_C_EXTERNAL_TRIGGER_SOURCE = 2;
  localparam int RXPRT_C_BIN = 3;
  localparam int RXPRT_C_PCT = 4;
  localparam int RXPRT_C_REFPCT = 5;
  localparam int RXPRT_C_STAT = 6;
  localparam int RXPRT_C_AUTOMEM = 7;
  localparam int RXPRT_C_RISE = 8;
  localparam int RXPRT_C_COMPACT = 9;
  localparam int RXPRT_K_PRINT = 0;
  localparam int RXPRT_K_STATPRT = 1;
  localparam int RXPRT_K_QUERY = 2;
  localparam logic [9:0] RXPRT_CTRL_RST = 10'h002;
  typedef enum logic [1:0] {
    RXPRT_J_IN = 2'h0,
    RXPRT_J_HI = 2'h1,
    RXPRT_J_LO = 2'h2,
    RXPRT_J_NONE = 2'h3
  } rxprt_judge_e;
  typedef struct packed {
    logic over_range_marker;
    logic fault;
    rxprt_judge_e judge;
    logic [31:0] value;
  } rxprt_meas_s;
  typedef enum logic [5:0] {
    RXPRT_S_IDLE = 6'h01,
    RXPRT_S_LOAD = 6'h02,
    RXPRT_S_DIG = 6'h04,
    RXPRT_S_EMIT = 6'h08,
    RXPRT_S_WAIT = 6'h10,
    RXPRT_S_CLEAR = 6'h20
  } rxprt_state_e;
endpackage

// >>> rtl/rxprt_sequencer.sv
`timescale 1ns/100ps
module rxprt_sequencer
  import rxprt_pkg::*;
#(
  parameter int unsigned BIT_CYC = RXPRT_BIT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic meas_done,
  input wire rxprt_meas_s meas_in,
  input wire logic measure_trigger_in,
  input wire logic print_req_n,
  input wire logic [15:0] valid_count,
  output logic txd,
  output logic meas_start,
  output logic stat_add,
  output logic stat_clear
);
  initial begin
    if (BIT_CYC < 2 || BIT_CYC > 65536) $error("BIT_CYC out of range");
  end

  function automatic logic [7:0] judge_char(input rxprt_judge_e j, input logic second);
    case (j)
      RXPRT_J_HI: judge_char = second ? RXPRT_CH_I : RXPRT_CH_H;
      RXPRT_J_LO: judge_char = second ? RXPRT_CH_O : RXPRT_CH_L;
      RXPRT_J_IN: judge_char = second ? RXPRT_CH_N : RXPRT_CH_I;
      default: judge_char = RXPRT_CH_MINUS;
    endcase
  endfunction

  logic [9:0] ctrl;
  logic [31:0] ref_val;
  rxprt_meas_s cur;
  rxprt_state_e state;
  logic measure_trigger_in_armed, pend_exp, pend_prt, pend_stat, pend_query;
  logic print_d, measure_trigger_in_d;
  logic [31:0] mant;
  logic neg;
  logic [3:0] expo;
  logic [31:0] diff;
  logic [63:0] ratio;
  logic [7:0] line [0:15];
  logic [3:0] len, idx, dcnt;
  logic [31:0] work;
  logic [7:0] col;
  logic [1:0] pairs;
  logic busy, clear_job;
  logic [1:0] stat_job;
  logic [15:0] bitcnt;
  logic [3:0] bitno;
  logic [8:0] shreg;
  logic tx_busy, tx_go;
  logic [7:0] tx_byte;
  logic a_ph, a_wr;
  logic [7:0] a_addr;

  wire measure_trigger_in_edge = ctrl[RXPRT_C_RISE] ? (measure_trigger_in & ~measure_trigger_in_d)
                                      : (~measure_trigger_in & measure_trigger_in_d);
  wire print_fall = ~print_req_n & print_d;
  wire serial_ok = ctrl[RXPRT_C_IF_SER];
  wire stat_on = ctrl[RXPRT_C_STAT] | ctrl[RXPRT_C_AUTOMEM];
  wire cmd_wr = a_ph & a_wr & (a_addr == RXPRT_ADDR_CMD);
  wire key_print = cmd_wr & hwdata[RXPRT_K_PRINT];
  wire key_stat = cmd_wr & hwdata[RXPRT_K_STATPRT];
  wire key_query = cmd_wr & hwdata[RXPRT_K_QUERY];

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_ph <= 1'b0;
      a_wr <= 1'b0;
      a_addr <= 8'h00;
    end else if (hready) begin
      a_ph <= hsel & htrans[1];
      a_wr <= hwrite;
      a_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= RXPRT_CTRL_RST;
      ref_val <= 32'h0000_0000;
      cur <= '0;
    end else begin
      if (a_ph && a_wr && a_addr == RXPRT_ADDR_CTRL) ctrl <= hwdata[9:0];
      if (a_ph && a_wr && a_addr == RXPRT_ADDR_REF) ref_val <= hwdata;
      if (meas_done) cur <= meas_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          RXPRT_ADDR_CTRL: hrdata <= {22'h0, ctrl};
          RXPRT_ADDR_STAT: hrdata <= {26'h0, pend_query, pend_stat, pend_prt,
                                      pend_exp, tx_busy, busy};
          RXPRT_ADDR_VAL: hrdata <= {16'h0, valid_count};
          RXPRT_ADDR_REF: hrdata <= ref_val;
          RXPRT_ADDR_MEAS: hrdata <= cur.value;
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Input edges and trigger side effects
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      print_d <= 1'b1;
      measure_trigger_in_d <= 1'b1;
      measure_trigger_in_armed <= 1'b0;
      meas_start <= 1'b0;
      stat_add <= 1'b0;
    end else begin
      print_d <= print_req_n;
      measure_trigger_in_d <= measure_trigger_in;
      meas_start <= measure_trigger_in_edge & ctrl[RXPRT_C_EXTERNAL_TRIGGER_SOURCE];
      stat_add <= (measure_trigger_in_edge & ctrl[RXPRT_C_STAT])
                | ((print_fall | key_print) & ctrl[RXPRT_C_STAT]
                   & ~ctrl[RXPRT_C_EXTERNAL_TRIGGER_SOURCE]);
      if (measure_trigger_in_edge) measure_trigger_in_armed <= 1'b1;
      else if (meas_done) measure_trigger_in_armed <= 1'b0;
    end
  end

  // Pending jobs: a new request wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_exp <= 1'b0;
      pend_prt <= 1'b0;
      pend_stat <= 1'b0;
      pend_query <= 1'b0;
    end else begin
      if (state == RXPRT_S_LOAD) begin
        pend_exp <= 1'b0;
        pend_prt <= 1'b0;
        pend_stat <= 1'b0;
        pend_query <= 1'b0;
      end
      if (meas_done && ctrl[RXPRT_C_OUT_EN] && serial_ok
          && (ctrl[RXPRT_C_EXTERNAL_TRIGGER_SOURCE] || measure_trigger_in_armed || measure_trigger_in_edge))
        pend_exp <= 1'b1;
      if ((print_fall && !stat_on) || key_print) pend_prt <= 1'b1;
      if ((print_fall || key_stat) && stat_on) pend_stat <= 1'b1;
      if (key_query) pend_query <= 1'b1;
    end
  end

  // Value in ten-thousandths shaped to mantissa/exponent
  always_comb begin
    neg = cur.value[31];
    mant = neg ? (~cur.value + 32'h1) : cur.value;
    expo = RXPRT_EXP_NORMAL;
    diff = 32'h0;
    ratio = 64'h0;
    if (ctrl[RXPRT_C_PCT] && ctrl[RXPRT_C_REFPCT]) begin
      neg = $signed(cur.value) < $signed(ref_val);
      diff = neg ? (ref_val - cur.value) : (cur.value - ref_val);
      // Deviation relative to the reference, a zero reference saturates
      ratio = (ref_val == 32'h0) ? {32'h0, RXPRT_PCT_LIMIT}
            : ({32'h0, diff} * {32'h0, RXPRT_MANT_100}) / {32'h0, ref_val};
      mant = (ratio > {32'h0, RXPRT_PCT_LIMIT}) ? RXPRT_PCT_LIMIT : ratio[31:0];
      if (cur.over_range_marker) begin
        mant = RXPRT_MANT_100;
        expo = RXPRT_EXP_OVER;
      end
      if (cur.fault) begin
        mant = RXPRT_MANT_100;
        expo = RXPRT_EXP_FAULT;
        neg = 1'b0;
      end
    end
  end

  // Formatter and print sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= RXPRT_S_IDLE;
      len <= 4'h0;
      idx <= 4'h0;
      dcnt <= 4'h0;
      work <= 32'h0;
      col <= 8'h0;
      pairs <= 2'h0;
      busy <= 1'b0;
      clear_job <= 1'b0;
      stat_job <= 2'h0;
      stat_clear <= 1'b0;
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
      for (int i = 0; i < 16; i++) line[i] <= 8'h00;
    end else begin
      tx_go <= 1'b0;
      stat_clear <= 1'b0;
      case (state)
        RXPRT_S_IDLE: begin
          busy <= 1'b0;
          if (pend_exp || pend_prt || pend_stat || pend_query) begin
            busy <= 1'b1;
            // Data set record always, more records only with valid samples
            stat_job <= !pend_stat ? 2'h0 : (valid_count == 16'h0) ? 2'h0
                      : (valid_count == 16'h1) ? 2'h1 : 2'h2;
            clear_job <= pend_stat;
            state <= RXPRT_S_LOAD;
          end
        end
        RXPRT_S_LOAD: begin
          line[0] <= neg ? RXPRT_CH_MINUS : RXPRT_CH_PLUS;
          work <= mant;
          dcnt <= RXPRT_DIGITS;
          if (ctrl[RXPRT_C_BIN] && !pend_prt && !pend_stat) begin
            line[0] <= RXPRT_BIN_SYNC;
            line[1] <= {3'h0, neg, expo};
            line[2] <= mant[31:24];
            line[3] <= mant[23:16];
            line[4] <= mant[15:8];
            line[5] <= mant[7:0];
            len <= 4'h5;
            idx <= 4'h0;
            state <= RXPRT_S_EMIT;
          end else begin
            state <= RXPRT_S_DIG;
          end
        end
        RXPRT_S_DIG: begin
          // Fraction point sits before the last four digits
          if (dcnt != 4'h0) begin
            line[dcnt + ((dcnt > RXPRT_DIGITS - RXPRT_FRAC_POS) ? 4'h1 : 4'h0)]
              <= RXPRT_CH_ZERO + 8'(work % 10);
            work <= work / 10;
            dcnt <= dcnt - 4'h1;
          end else begin
            line[RXPRT_DIGITS - RXPRT_FRAC_POS + 4'h1] <= RXPRT_CH_DOT;
            line[12] <= RXPRT_CH_E;
            line[13] <= RXPRT_CH_ZERO + {4'h0, expo};
            line[14] <= ctrl[RXPRT_C_COMPACT] ? RXPRT_CH_SLASH : RXPRT_CH_SP;
            line[15] <= judge_char(cur.judge, 1'b0);
            len <= 4'hf;
            idx <= 4'h0;
            state <= RXPRT_S_EMIT;
          end
        end
        RXPRT_S_EMIT: begin
          if (!tx_busy && !tx_go) begin
            tx_byte <= line[idx];
            tx_go <= 1'b1;
            col <= col + 8'h1;
            state <= RXPRT_S_WAIT;
          end
        end
        RXPRT_S_WAIT: begin
          if (!tx_busy && !tx_go) begin
            if (idx != len) begin
              idx <= idx + 4'h1;
              state <= RXPRT_S_EMIT;
            end else begin
              tx_byte <= judge_char(cur.judge, 1'b1);
              pairs <= pairs + 2'h1;
              // Compact layout breaks after a set of pairs, normal per value
              if (!ctrl[RXPRT_C_COMPACT] || pairs == 2'(RXPRT_PAIRS_PER_LINE - 1)
                  || col >= 8'(RXPRT_LINE_MAX - 16)) begin
                line[0] <= RXPRT_CH_CR;
                line[1] <= RXPRT_CH_LF;
                pairs <= 2'h0;
                col <= 8'h0;
              end else begin
                line[0] <= RXPRT_CH_SP;
                line[1] <= RXPRT_CH_SP;
              end
              tx_go <= 1'b1;
              idx <= 4'h0;
              len <= 4'h1;
              state <= RXPRT_S_CLEAR;
            end
          end
        end
        RXPRT_S_CLEAR: begin
          if (!tx_busy && !tx_go) begin
            if (len != 4'h0 || idx != 4'h2) begin
              tx_byte <= line[idx[0]];
              tx_go <= idx != 4'h2;
              idx <= idx + 4'h1;
              len <= 4'h0;
            end else if (stat_job != 2'h0) begin
              // Next enable_a record, pending requests stay untouched
              stat_job <= stat_job - 2'h1;
              line[0] <= neg ? RXPRT_CH_MINUS : RXPRT_CH_PLUS;
              work <= mant;
              dcnt <= RXPRT_DIGITS;
              state <= RXPRT_S_DIG;
            end else begin
              if (clear_job) stat_clear <= 1'b1;
              clear_job <= 1'b0;
              state <= RXPRT_S_IDLE;
            end
          end
        end
        default: state <= RXPRT_S_IDLE;
      endcase
    end
  end

  // UART transmitter, 8N1, no flow control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd <= 1'b1;
      tx_busy <= 1'b0;
      bitcnt <= 16'h0;
      bitno <= 4'h0;
      shreg <= 9'h1ff;
    end else if (!tx_busy) begin
      if (tx_go) begin
        tx_busy <= 1'b1;
        txd <= 1'b0;
        shreg <= {1'b1, tx_byte};
        bitcnt <= 16'(BIT_CYC - 1);
        bitno <= 4'h0;
      end
    end else if (bitcnt != 16'h0) begin
      bitcnt <= bitcnt - 16'h1;
    end else begin
      bitcnt <= 16'(BIT_CYC - 1);
      if (bitno == 4'h9) begin
        tx_busy <= 1'b0;
        txd <= 1'b1;
      end else begin
        txd <= shreg[0];
        shreg <= {1'b1, shreg[8:1]};
        bitno <= bitno + 4'h1;
      end
    end
  end

  logic unused;
  assign unused = ^hsize;
endmodule

// >>> verification/rxprt_sequencer_props.sv
`timescale 1ns/100ps
module rxprt_sequencer_props
  import rxprt_pkg::*;
#(parameter int unsigned BIT_CYC = RXPRT_BIT_CYC) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic measure_trigger_in,
  input wire logic txd,
  input wire logic meas_start,
  input wire logic stat_add,
  input wire logic stat_clear
);
  logic [9:0] ctrl;
  logic wr_q;
  int low;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of the control word, taken from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      ctrl <= RXPRT_CTRL_RST;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == RXPRT_ADDR_CTRL;
      if (wr_q) begin
        ctrl <= hwdata[9:0];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low <= 0;
    end else begin
      low <= txd ? 0 : low + 1;
    end
  end
  sequence s_fall; $fell(measure_trigger_in); endsequence
  sequence s_rise; $rose(measure_trigger_in); endsequence
  sequence s_start; ##[1:6] meas_start; endsequence
  chk_bit_width: assert property ($rose(txd) |-> low > 0 && low % BIT_CYC == 0)
    else $error("txd low run is not whole bits");
  chk_fall_start: assert property (ctrl[2] && !ctrl[8] ##0 s_fall |-> s_start)
    else $error("no start on falling trigger");
  chk_rise_start: assert property (ctrl[2] && ctrl[8] ##0 s_rise |-> s_start)
    else $error("no start on rising trigger");
  chk_int_no_start: assert property (!ctrl[2] |-> !meas_start)
    else $error("start with internal trigger");
  chk_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  chk_add_pulse: assert property (stat_add |=> !stat_add)
    else $error("add longer than one cycle");
  chk_add_gate: assert property (stat_add |-> ctrl[6] || ctrl[7])
    else $error("add with enable_a off");
  chk_clear_gate: assert property (stat_clear |-> ctrl[6] || ctrl[7])
    else $error("clear with enable_a off");
  chk_clear_idle: assert property (stat_clear |-> txd && $past(txd))
    else $error("clear before printout ended");
endmodule

bind rxprt_sequencer rxprt_sequencer_props #(.BIT_CYC(BIT_CYC)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .measure_trigger_in(measure_trigger_in), .txd(txd), .meas_start(meas_start),
  .stat_add(stat_add), .stat_clear(stat_clear)
);

// >>> verification/rxprt_printer_model.sv
`timescale 1ns/100ps
module rxprt_printer_model
  import rxprt_pkg::*;
#(parameter int unsigned BIT_CYC = 4) (
  input wire logic clk,
  input wire logic rxd
);
  logic [7:0] q[$];
  logic [7:0] b;
  int bad;
  int col;
  // No flow control lines: the printer just samples mid-bit
  initial begin
    bad = 0;
    col = 0;
    forever begin
      @(negedge rxd);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        b[i] = rxd;
      end
      repeat (BIT_CYC) @(posedge clk);
      bad += (rxd !== 1'b1);
      col = (b == RXPRT_CH_LF) ? 0 : col + 1;
      bad += (col > RXPRT_LINE_MAX + 1);
      q.push_back(b);
    end
  end
endmodule

// >>> verification/rxprt_sequencer_tb.sv
`timescale 1ns/100ps
module rxprt_sequencer_tb;
  import rxprt_pkg::*;
  localparam int unsigned BC = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, meas_done;
  logic measure_trigger_in, print_req_n, txd, meas_start, stat_add, stat_clear;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] valid_count;
  rxprt_meas_s meas_in;
  int err_total, checks, adds, clears, starts;
  assign hready = hreadyout;
  rxprt_sequencer #(.BIT_CYC(BC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_done(meas_done), .meas_in(meas_in),
    .measure_trigger_in(measure_trigger_in), .print_req_n(print_req_n),
    .valid_count(valid_count), .txd(txd), .meas_start(meas_start),
    .stat_add(stat_add), .stat_clear(stat_clear)
  );
  rxprt_printer_model #(.BIT_CYC(BC)) rx (.clk(hclk), .rxd(txd));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    adds += (stat_add === 1'b1);
    clears += (stat_clear === 1'b1);
    starts += (meas_start === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task tmo;
    err_total++;
    $display("[ERR] %0t wait timed out", $time);
    finish_test;
  endtask
  task rdy;
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (n == 50) tmo;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task ctl(input logic [31:0] c);
    bus(1'b1, RXPRT_ADDR_CTRL, c);
  endtask
  // Returns once the line has been idle for 25 bit times
  task quiet;
    int n, idle;
    idle = 0;
    repeat (20) @(posedge hclk);
    for (n = 0; n < 40000 && idle < 100; n++) begin
      @(posedge hclk);
      idle = (txd === 1'b1) ? idle + 1 : 0;
    end
    if (idle < 100) tmo;
  endtask
  task key(input logic [31:0] c);
    rx.q.delete();
    bus(1'b1, RXPRT_ADDR_CMD, c);
    quiet;
  endtask
  task meas(input logic ovr, input logic flt, input logic trg);
    rx.q.delete();
    measure_trigger_in <= ~trg;
    repeat (8) @(posedge hclk);
    measure_trigger_in <= 1'b1;
    repeat (8) @(posedge hclk);
    meas_in <= '{ovr, flt, RXPRT_J_IN, 32'h0000_3039};
    meas_done <= 1'b1;
    @(posedge hclk);
    meas_done <= 1'b0;
    quiet;
  endtask
  task t_regs;
    bus(1'b0, RXPRT_ADDR_CTRL, 32'h0);
    chk(rd, {22'h0, RXPRT_CTRL_RST});
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    bus(1'b0, RXPRT_ADDR_VAL, 32'h0);
    chk(rd, {16'h0, valid_count});
    $display("t_regs done");
  endtask
  task t_export;
    ctl(32'h003);
    meas(1'b0, 1'b0, 1'b0);
    chk(rx.q.size(), 32'h0);
    meas(1'b0, 1'b0, 1'b1);
    chk(32'(rx.q[0]), 32'(RXPRT_CH_PLUS));
    chk(32'(rx.q[$]), 32'(RXPRT_CH_LF));
    chk(rx.q.size(), 32'h13);
    bus(1'b0, RXPRT_ADDR_MEAS, 32'h0);
    chk(rd, 32'h0000_3039);
    ctl(32'h00b);
    meas(1'b0, 1'b0, 1'b1);
    chk(32'(rx.q[0]), 32'(RXPRT_BIN_SYNC));
    chk(rx.q.size(), 32'h9);
    // Query only once the export has drained, never overlapping it
    key(32'h4);
    chk(32'(rx.q[0]), 32'(RXPRT_BIN_SYNC));
    chk(rx.q.size(), 32'h9);
    ctl(32'h001);
    meas(1'b0, 1'b0, 1'b1);
    chk(rx.q.size(), 32'h0);
    $display("t_export done");
  endtask
  // Export one value against reference r and decode its ten digits
  task t_lim(input logic [31:0] r, input logic [31:0] exp_v);
    logic [31:0] v;
    v = 32'h0;
    bus(1'b1, RXPRT_ADDR_REF, r);
    meas(1'b0, 1'b0, 1'b1);
    for (int j = 1; j < 12; j++) begin
      if (j != 7) v = v * 32'ha + 32'(rx.q[j] - RXPRT_CH_ZERO);
    end
    chk(32'(rx.q[7]), 32'(RXPRT_CH_DOT));
    chk(v, exp_v);
  endtask
  task t_pct;
    logic [7:0] e;
    logic [3:0] x;
    ctl(32'h033);
    for (int i = 0; i < 3; i++) begin
      meas(i == 1, i == 2, 1'b1);
      e = 8'h0;
      foreach (rx.q[j]) begin
        if (j > 0 && rx.q[j - 1] == RXPRT_CH_E) begin
          e = rx.q[j];
        end
      end
      x = (i == 0) ? RXPRT_EXP_NORMAL : (i == 1) ? RXPRT_EXP_OVER : RXPRT_EXP_FAULT;
      chk(32'(e), 32'(RXPRT_CH_ZERO) + 32'(x));
    end
    t_lim(32'h0000_2710, 32'h0003_9404);
    t_lim(32'h0000_0001, 32'h0098_9676);
    $display("t_pct done");
  endtask
  task t_print;
    int a;
    ctl(32'h042);
    a = adds;
    key(32'h1);
    chk(adds - a, 32'h1);
    chk(32'(rx.q[$]), 32'(RXPRT_CH_LF));
    ctl(32'h046);
    a = adds;
    key(32'h1);
    chk(adds - a, 32'h0);
    chk(32'(rx.q.size() > 0), 32'h1);
    ctl(32'h202);
    key(32'h1);
    chk(32'(rx.q[$]), 32'(RXPRT_CH_SP));
    ctl(32'h002);
    rx.q.delete();
    print_req_n <= 1'b0;
    repeat (8) @(posedge hclk);
    print_req_n <= 1'b1;
    quiet;
    chk(32'(rx.q.size() > 0), 32'h1);
    $display("t_print done");
  endtask
  task t_stat;
    int c, sz[3];
    ctl(32'h002);
    key(32'h2);
    chk(rx.q.size(), 32'h0);
    ctl(32'h042);
    for (int v = 0; v < 3; v++) begin
      valid_count <= 16'(v);
      c = clears;
      key(32'h2);
      sz[v] = rx.q.size();
      chk(clears - c, 32'h1);
    end
    chk(32'(sz[0] < sz[1]), 32'h1);
    chk(32'(sz[1] < sz[2]), 32'h1);
    chk(rx.bad, 32'h0);
    $display("t_stat done");
  endtask
  task t_measure_trigger_in;
    int s;
    for (int r = 0; r < 2; r++) begin
      ctl(r ? 32'h104 : 32'h004);
      s = starts;
      measure_trigger_in <= 1'b0;
      repeat (10) @(posedge hclk);
      chk(starts - s, 32'(1 - r));
      measure_trigger_in <= 1'b1;
      repeat (10) @(posedge hclk);
      chk(starts - s, 32'h1);
    end
    $display("t_measure_trigger_in done");
  endtask
  initial begin
    {hresetn, hsel, hwrite, meas_done, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    meas_in = '0;
    measure_trigger_in = 1'b1;
    print_req_n = 1'b1;
    valid_count = 16'h0002;
    {err_total, checks, adds, clears, starts} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_export;
    t_pct;
    t_print;
    t_stat;
    t_measure_trigger_in;
    finish_test;
  end
endmodule
